// ### verilog/pwm_unit_cfg.svh
// constants for the enhanced capture/pwm unit: mode codes, field positions, counts
// assumes inclusion by the unit's design file; the unit package does not include it
`ifndef PWM_UNIT_CFG_SVH
`define PWM_UNIT_CFG_SVH

// ----------------------------------------------------------------
// clocking
// ----------------------------------------------------------------
`define REF_CLK_MHZ 100
`define INSTR_DIV_LAST 2'h3

// ----------------------------------------------------------------
// unit_mode_bits fields
// ----------------------------------------------------------------
`define MODE_PWM_HI 3
`define MODE_PWM_LO 2
`define MODE_PWM_CODE 2'h3
`define MODE_SPECIAL_EVENT 4'hb
`define POL_AC_LOW_BIT 1
`define POL_BD_LOW_BIT 0

// ----------------------------------------------------------------
// dead band and shutdown sources
// ----------------------------------------------------------------
`define DEADBAND_MAX 7'h7f
`define SRC_PIN_BIT 0
`define SRC_CMP_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TIMER1_RESET 16'h0000
`define TIMER2_RESET 8'h00

`endif

// ### verilog/pwm_unit_pkg.sv
// types shared by the enhanced capture/pwm unit
// assumes the config header sits beside it
package pwm_unit_pkg;

  // output configuration, listed in output_config_bits code order
  typedef enum logic [1:0] {
    CFG_SINGLE,
    CFG_FULL_FWD,
    CFG_HALF,
    CFG_FULL_REV
  } out_cfg_e;

endpackage

// ### verilog/input_sync.sv
// two-stage synchroniser for pins arriving from outside the clock domain
// assumes a single clock and an active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none

module input_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ### verilog/enhanced_pwm_unit.sv
// enhanced capture/pwm unit: timer1 special event, pwm time base, dead band,
// output steering, polarity and auto-shutdown with optional restart
// assumes software-side inputs come from logic on REF_CLK; shutdown pins are async
//
// Function
// [RL1] special event resets timer1 pair
// [RL2] pin use follows mode bits
// [RL3] half-bridge drives signal and complement
// [RL4] deadband_count delays each active edge
// [RL5] dead band beyond duty keeps output inactive
// [RL6] auto_restart_enable permits automatic restart
// [RL7] auto restart: flag follows shutdown cause
// [RL8] no auto restart: flag sticky until cleared
// [RL9] resume only at next period start
// [RL10] flag writes ignored during shutdown cause
// [RL11] comparator shutdown always level sensitive
// [RL12] writing one forces shutdown state
// [RL13] polarity chosen per output pair
// [RL14] software sets polarity before enabling pins
// [RL15] software waits one cycle before pins
// [RL16] period flag set at second period
// [RL17] software clears direction bits for a/b
// [RL18] pins undriven after reset until configured
// [RL19] pwm uses timer2, compare uses timer1
// [RL20] software selects config and mode bits
// [RL21] shutdown holds outputs at inactive level
`include "pwm_unit_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module enhanced_pwm_unit (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [3:0] UNIT_MODE_BITS,
  input wire logic [1:0] OUTPUT_CONFIG_BITS,
  input wire logic [6:0] DEADBAND_COUNT,
  input wire logic AUTO_RESTART_ENABLE,
  input wire logic [7:0] PERIOD_VALUE,
  input wire logic [7:0] DUTY_VALUE,
  input wire logic [15:0] COMPARE_VALUE,
  input wire logic [1:0] SHUTDOWN_SOURCE_ENABLE,
  input wire logic SHUTDOWN_PIN,
  input wire logic COMPARATOR_TRIP,
  input wire logic FLAG_WRITE,
  input wire logic FLAG_WRITE_DATA,
  input wire logic PERIOD_FLAG_CLEAR,
  input wire logic [3:0] PIN_DIR_OUTPUT,
  output logic [15:0] TIMER1_COUNT,
  output logic SPECIAL_EVENT,
  output logic SHUTDOWN_EVENT_FLAG,
  output logic TIMEBASE_PERIOD_FLAG,
  output logic PWM_OUT_A,
  output logic PWM_OUT_B,
  output logic PWM_OUT_C,
  output logic PWM_OUT_D,
  output logic PWM_OUT_A_OE,
  output logic PWM_OUT_B_OE,
  output logic PWM_OUT_C_OE,
  output logic PWM_OUT_D_OE
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] div_reg;
  logic [15:0] timer1_count_pair_reg;
  logic sev_reg;
  logic [7:0] tmr2_reg;
  logic run_reg;
  logic raw_reg;
  logic [6:0] db_reg;
  logic flag_reg;
  logic forced_reg;
  logic pflag_reg;
  logic [3:0] out_reg;
  logic [1:0] sd_sync;
  logic ice;
  logic pwm_mode;
  logic sev_mode;
  logic sev_hit;
  logic period_start;
  logic raw;
  logic db_done;
  logic act_a;
  logic act_b;
  logic cause;
  logic pol_ac;
  logic pol_bd;
  logic [3:0] act;
  logic [3:0] used;
  logic [3:0] level;
  pwm_unit_pkg::out_cfg_e cfg;

  // shutdown pins come from outside the clock domain
  input_sync #(.WIDTH(2)) u_sd_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .async_in({COMPARATOR_TRIP, SHUTDOWN_PIN}),
    .sync_out(sd_sync)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // instruction cycle is one in four reference clocks
  assign ice = (div_reg == `INSTR_DIV_LAST);
  assign pwm_mode = (UNIT_MODE_BITS[`MODE_PWM_HI:`MODE_PWM_LO] == `MODE_PWM_CODE);
  assign sev_mode = (UNIT_MODE_BITS == `MODE_SPECIAL_EVENT);
  assign cfg = pwm_unit_pkg::out_cfg_e'(OUTPUT_CONFIG_BITS);
  // [RL19] timer2 period base
  assign period_start = pwm_mode && ice && (tmr2_reg == PERIOD_VALUE);
  // [RL1] compare match trigger
  assign sev_hit = sev_mode && ice && (timer1_count_pair_reg == COMPARE_VALUE);
  assign raw = run_reg && (tmr2_reg < DUTY_VALUE);
  // [RL11] comparator cause is a live level
  assign cause = (sd_sync[`SRC_PIN_BIT] && SHUTDOWN_SOURCE_ENABLE[`SRC_PIN_BIT])
               || (sd_sync[`SRC_CMP_BIT] && SHUTDOWN_SOURCE_ENABLE[`SRC_CMP_BIT]);

  // ----------------------------------------------------------------
  // dead band and steering
  // ----------------------------------------------------------------
  // [RL4] active edge waits deadband_count cycles
  assign db_done = (db_reg >= DEADBAND_COUNT);
  // [RL5] dead band longer than duty never reaches active
  assign act_a = raw_reg && db_done;
  // [RL3] complement on b with its own delay
  assign act_b = !raw_reg && db_done;
  // [RL2] pin use per output configuration
  assign act = (cfg == pwm_unit_pkg::CFG_HALF) ? {2'b00, act_b, act_a} :
               (cfg == pwm_unit_pkg::CFG_FULL_FWD) ? {raw_reg, 3'b001} :
               (cfg == pwm_unit_pkg::CFG_FULL_REV) ? {2'b01, raw_reg, 1'b0} :
               {3'b000, raw_reg};
  assign used = !pwm_mode ? 4'h0 :
                (cfg == pwm_unit_pkg::CFG_SINGLE) ? 4'h1 :
                (cfg == pwm_unit_pkg::CFG_HALF) ? 4'h3 : 4'hf;
  // [RL13] per-pair polarity
  assign pol_ac = UNIT_MODE_BITS[`POL_AC_LOW_BIT];
  assign pol_bd = UNIT_MODE_BITS[`POL_BD_LOW_BIT];
  // [RL21] stopped outputs sit at the inactive level
  assign level = (run_reg ? act : 4'h0) ^ {pol_bd, pol_ac, pol_bd, pol_ac};

  // divider and timer1; special event clears the pair
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_reg <= 2'h0;
      timer1_count_pair_reg <= `TIMER1_RESET;
      sev_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      sev_reg <= sev_hit;
      if (sev_hit) begin
        timer1_count_pair_reg <= `TIMER1_RESET;
      end else if (ice) begin
        timer1_count_pair_reg <= timer1_count_pair_reg + 16'h0001;
      end
    end
  end

  // timer2 base, modulated level and dead band counter
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tmr2_reg <= `TIMER2_RESET;
      raw_reg <= 1'b0;
      db_reg <= 7'h00;
    end else if (!pwm_mode) begin
      tmr2_reg <= `TIMER2_RESET;
      raw_reg <= 1'b0;
      db_reg <= 7'h00;
    end else if (ice) begin
      tmr2_reg <= period_start ? `TIMER2_RESET : tmr2_reg + 8'h01;
      raw_reg <= raw;
      if (raw != raw_reg) begin
        db_reg <= 7'h00;
      end else if (db_reg != `DEADBAND_MAX) begin
        db_reg <= db_reg + 7'h01;
      end
    end
  end

  // shutdown flag: a live cause beats any write, so writes are void meanwhile
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flag_reg <= 1'b0;
      forced_reg <= 1'b0;
    end else if (cause) begin
      // [RL10] cause wins over writes
      flag_reg <= 1'b1;
    end else if (FLAG_WRITE) begin
      // [RL12] writing one forces shutdown
      flag_reg <= FLAG_WRITE_DATA;
      forced_reg <= FLAG_WRITE_DATA;
    end else if (AUTO_RESTART_ENABLE && !forced_reg) begin
      // [RL6] [RL7] restart clears once cause is gone; [RL8] otherwise held
      flag_reg <= 1'b0;
    end
  end

  // run gate: stops at once, restarts only on a period boundary
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_reg <= 1'b0;
    end else if (!pwm_mode || flag_reg) begin
      run_reg <= 1'b0;
    end else if (period_start) begin
      // [RL9] resume at next period
      run_reg <= 1'b1;
    end
  end

  // period flag is set on each rollover, first at the start of period two
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pflag_reg <= 1'b0;
    end else if (period_start) begin
      // [RL16] set at period boundary
      pflag_reg <= 1'b1;
    end else if (PERIOD_FLAG_CLEAR) begin
      pflag_reg <= 1'b0;
    end
  end

  // output pin levels
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_reg <= 4'h0;
    end else begin
      out_reg <= level;
    end
  end

  // [RL18] pins driven only when configured as outputs in use
  assign {PWM_OUT_D_OE, PWM_OUT_C_OE, PWM_OUT_B_OE, PWM_OUT_A_OE} = used & PIN_DIR_OUTPUT;
  assign {PWM_OUT_D, PWM_OUT_C, PWM_OUT_B, PWM_OUT_A} = out_reg;
  assign TIMER1_COUNT = timer1_count_pair_reg;
  assign SPECIAL_EVENT = sev_reg;
  assign SHUTDOWN_EVENT_FLAG = flag_reg;
  assign TIMEBASE_PERIOD_FLAG = pflag_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_sev_clear;
    @(posedge REF_CLK) disable iff (!RST_B)
      sev_hit |=> (timer1_count_pair_reg == 16'h0000) && sev_reg;
  endproperty
  a_sev_clear: assert property (p_sev_clear) else $error("timer1 not cleared by event"); // [RL1]

  property p_pin_use;
    @(posedge REF_CLK) disable iff (!RST_B)
      (cfg != pwm_unit_pkg::CFG_FULL_FWD && cfg != pwm_unit_pkg::CFG_FULL_REV)
        |-> !PWM_OUT_C_OE && !PWM_OUT_D_OE;
  endproperty
  a_pin_use: assert property (p_pin_use) else $error("c or d driven outside quad"); // [RL2]

  property p_half_compl;
    @(posedge REF_CLK) disable iff (!RST_B)
      (cfg == pwm_unit_pkg::CFG_HALF && DEADBAND_COUNT == 7'h00 && run_reg)
        |-> (act[0] != act[1]);
  endproperty
  a_half_compl: assert property (p_half_compl) else $error("half bridge not complementary"); // [RL3]

  property p_dead_band;
    @(posedge REF_CLK) disable iff (!RST_B)
      (act_a || act_b) |-> (db_reg >= DEADBAND_COUNT) && !(act_a && act_b);
  endproperty
  a_dead_band: assert property (p_dead_band) else $error("active before dead band"); // [RL4]

  property p_auto_clear;
    @(posedge REF_CLK) disable iff (!RST_B)
      (flag_reg && AUTO_RESTART_ENABLE && !forced_reg && !cause && !FLAG_WRITE)
        |=> !flag_reg;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto restart flag stuck"); // [RL7]

  property p_sticky;
    @(posedge REF_CLK) disable iff (!RST_B)
      (flag_reg && !AUTO_RESTART_ENABLE && !FLAG_WRITE) |=> flag_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared without write"); // [RL8]

  property p_resume;
    @(posedge REF_CLK) disable iff (!RST_B)
      $rose(run_reg) |-> $past(period_start) && !$past(flag_reg);
  endproperty
  a_resume: assert property (p_resume) else $error("resumed mid period"); // [RL9]

  property p_write_void;
    @(posedge REF_CLK) disable iff (!RST_B)
      (cause && FLAG_WRITE && !FLAG_WRITE_DATA) |=> flag_reg;
  endproperty
  a_write_void: assert property (p_write_void) else $error("flag lost during cause"); // [RL10]

  property p_force;
    @(posedge REF_CLK) disable iff (!RST_B)
      (FLAG_WRITE && FLAG_WRITE_DATA) |=> flag_reg ##1 !run_reg;
  endproperty
  a_force: assert property (p_force) else $error("forced shutdown not entered"); // [RL12]

  property p_period_flag;
    @(posedge REF_CLK) disable iff (!RST_B)
      period_start |=> TIMEBASE_PERIOD_FLAG && (tmr2_reg == 8'h00);
  endproperty
  a_period_flag: assert property (p_period_flag) else $error("period flag not set"); // [RL16]

  property p_shut_level;
    @(posedge REF_CLK) disable iff (!RST_B)
      flag_reg ##1 flag_reg |=> (out_reg == {pol_bd, pol_ac, pol_bd, pol_ac});
  endproperty
  a_shut_level: assert property (p_shut_level) else $error("output active in shutdown"); // [RL21]

endmodule

`default_nettype wire

// ### testbench/bridge_stage_model.sv
// model of the external bridge switch stage hanging on the four pwm pins
// assumes board pull-downs hold every gate off while its pin is undriven
`timescale 1ns/10ps
`default_nettype none

module bridge_stage_model (
  input wire logic [3:0] pin,
  input wire logic [3:0] oe,
  output logic [3:0] gate,
  output logic shoot
);
  // -----------------------------------------------------------
  // gate levels
  // -----------------------------------------------------------
  // undriven means off
  assign gate = pin & oe;  // a released pin never shows its last value
  // both switches of leg a/b on together would short the supply rail
  assign shoot = gate[0] & gate[1];
endmodule

`default_nettype wire

// ### testbench/test_enhanced_pwm_unit.sv
// self-checking bench for the enhanced pwm unit with a bridge stage model
// assumes a 100 MHz REF_CLK and an instruction tick every fourth clock
`timescale 1ns/10ps
`default_nettype none

module test_enhanced_pwm_unit;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] mode = 4'h0;
  logic [1:0] cfg = 2'h0;
  logic [6:0] dead = 7'h00;
  logic arst = 1'b0;
  logic [7:0] per = 8'h09;
  logic [7:0] duty = 8'h04;
  logic [15:0] cmpv = 16'h0005;
  logic [1:0] src = 2'h0;
  logic sd_pin = 1'b0;
  logic cmp_trip = 1'b0;
  logic fw = 1'b0;
  logic fwd = 1'b0;
  logic pclr = 1'b0;
  logic [3:0] dir = 4'h0;
  logic [15:0] t1;
  logic sev, flag, pflag, pa, pb, pc, pd, shoot;
  logic [3:0] oe, gate;
  logic [15:0] na, nb, ne, nx, tmax;
  int err_count = 0;
  int check_count = 0;
  int c;
  logic [3:0] oe_exp [4] = '{4'h1, 4'hf, 4'h3, 4'hf};
  logic [6:0] dead_tab [3] = '{7'h00, 7'h02, 7'h05};

  always #5 ref_clk = ~ref_clk;

  enhanced_pwm_unit i_dut (
    .REF_CLK(ref_clk), .RST_B(rst_b), .UNIT_MODE_BITS(mode), .OUTPUT_CONFIG_BITS(cfg),
    .DEADBAND_COUNT(dead), .AUTO_RESTART_ENABLE(arst), .PERIOD_VALUE(per),
    .DUTY_VALUE(duty), .COMPARE_VALUE(cmpv), .SHUTDOWN_SOURCE_ENABLE(src),
    .SHUTDOWN_PIN(sd_pin), .COMPARATOR_TRIP(cmp_trip), .FLAG_WRITE(fw),
    .FLAG_WRITE_DATA(fwd), .PERIOD_FLAG_CLEAR(pclr), .PIN_DIR_OUTPUT(dir),
    .TIMER1_COUNT(t1), .SPECIAL_EVENT(sev), .SHUTDOWN_EVENT_FLAG(flag),
    .TIMEBASE_PERIOD_FLAG(pflag), .PWM_OUT_A(pa), .PWM_OUT_B(pb), .PWM_OUT_C(pc),
    .PWM_OUT_D(pd), .PWM_OUT_A_OE(oe[0]), .PWM_OUT_B_OE(oe[1]),
    .PWM_OUT_C_OE(oe[2]), .PWM_OUT_D_OE(oe[3])
  );

  bridge_stage_model i_stage (.pin({pd, pc, pb, pa}), .oe(oe), .gate(gate), .shoot(shoot));

  // -----------------------------------------------------------
  // tasks
  // -----------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // one-cycle strobe; flag is settled at the following falling edge
  task automatic wr_flag(input logic v);
    fwd = v;
    fw = 1'b1;
    tick(1);
    fw = 1'b0;
  endtask

  // counts over whole periods so the result does not depend on phase
  task automatic measure(input int n);
    na = 0; nb = 0; ne = 0; nx = 0; tmax = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      na += pa; nb += pb; ne += sev; nx += (pa === pb) | shoot;
      if (t1 > tmax) tmax = t1;
    end
    tick(1);
  endtask

  task automatic wait_pflag();
    c = 0;
    while (pflag !== 1'b1) begin
      tick(1);
      c++;
      if (c > 400) begin
        err_count++;
        $display("BAD period flag wait expected 1 seen %b", pflag);
        results();
      end
    end
  endtask

  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    tick(6);
    chk("oe in reset", oe, 4'h0);
    chk("gates in reset", gate, 4'h0);
    rst_b = 1'b1;
    cfg = 2'h2;
    mode = 4'hc;
    wait_pflag();
    chk("first period flag", pflag, 1'b1);
    pclr = 1'b1;
    tick(1);
    pclr = 1'b0;
    wait_pflag();
    chk("period length", c, 4 * (per + 1) - 1);
    dir = 4'hf;
    for (int i = 0; i < 4; i++) begin
      cfg = i[1:0];
      tick(1);
      chk("pin use", oe, oe_exp[i]);
    end
    cfg = 2'h2;
    dir = 4'h3;
    $display("done startup and pin use");
    for (int i = 0; i < 3; i++) begin
      dead = dead_tab[i];
      tick(80);
      measure(40);
      chk("a active", na, (duty > dead) ? 4 * (duty - dead) : 0);
      chk("b active", nb, 4 * (per + 1 - duty - dead));
      if (i == 0) chk("a equals b", nx, 0);
    end
    dead = 7'h00;
    for (int i = 0; i < 2; i++) begin
      dir = 4'h0;
      mode = i ? 4'he : 4'hf;
      tick(80);
      dir = 4'h3;
      measure(40);
      chk("a low polarity", na, 24);
      chk("b polarity", nb, i ? 24 : 16);
    end
    mode = 4'hc;
    $display("done dead band and polarity");
    arst = 1'b1;
    src = 2'h1;
    sd_pin = 1'b1;
    tick(4);
    chk("flag on pin", flag, 1'b1);
    wr_flag(1'b0);
    chk("write ignored", flag, 1'b1);
    measure(40);
    chk("a held off", na, 0);
    chk("b held off", nb, 0);
    sd_pin = 1'b0;
    tick(4);
    chk("auto clear", flag, 1'b0);
    // restart lines up with a period flag, so one full period follows it
    pclr = 1'b1;
    tick(1);
    pclr = 1'b0;
    wait_pflag();
    measure(40);
    chk("a resumed", na, 16);
    arst = 1'b0;
    sd_pin = 1'b1;
    tick(4);
    sd_pin = 1'b0;
    tick(8);
    chk("flag sticky", flag, 1'b1);
    wr_flag(1'b0);
    chk("flag cleared", flag, 1'b0);
    src = 2'h2;
    cmp_trip = 1'b1;
    tick(4);
    wr_flag(1'b0);
    chk("comparator level", flag, 1'b1);
    cmp_trip = 1'b0;
    tick(4);
    wr_flag(1'b0);
    chk("comparator cleared", flag, 1'b0);
    tick(1);
    wr_flag(1'b1);
    chk("forced flag", flag, 1'b1);
    measure(40);
    chk("forced a off", na, 0);
    wr_flag(1'b0);
    $display("done shutdown");
    // timer1 free-runs, so restart it from zero to reach the compare value soon
    rst_b = 1'b0;
    tick(2);
    chk("timer1 in reset", t1, 16'h0000);
    rst_b = 1'b1;
    mode = 4'hb;
    tick(8);
    measure(96);
    chk("timer1 top", tmax, cmpv);
    chk("special events", ne, 4);
    $display("done special event");
    results();
  end
endmodule

`default_nettype wire
